// ==== logic/i2c_slave_pkg.sv ====
// Function
// - bus clock up to 400 kHz handled; master never clocks faster
// - data bits sampled on clock rise; transmitter holds data while clock high
// - data change while clock high is start, repeated start or stop, never data
// - both lines released and resting high when the bus is idle
// - first byte after start carries the 7-bit address; respond only on match
// - address byte lsb selects direction: high read, low write
// - matching address byte is acknowledged in the ninth clock
// - register address acknowledged only when valid, otherwise not-acknowledged
// - every written data byte is acknowledged
// - pointer advances after each written byte, except it stays at register zero
// - read returns eight bits of the addressed register, msb first
// - master acks for more, nacks the last; device then releases data line
// - burst read keeps supplying bytes while the master keeps acknowledging
// - acknowledge pulls data low before and through the ninth clock high
// - not-acknowledge leaves data released high through the ninth clock
package i2c_slave_pkg;

    localparam int unsigned CORE_CLK_HZ      = 100_000_000;
    localparam int unsigned SCL_MAX_HZ       = 400_000;
    localparam int unsigned SCL_MIN_PERIOD_CYCLES =
        (CORE_CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;

    localparam logic [6:0] DEV_ADDR          = 7'h2A;
    localparam int unsigned RW_BIT_POS       = 0;
    localparam logic [7:0] REG_ADDR_MAX      = 8'h1F;
    localparam logic [7:0] REG_ADDR_HOLD     = 8'h00;

    localparam logic [7:0] POWER_OFF_COMMAND_OFFSET = 8'h1F;
    localparam logic [7:0] POWER_OFF_COMMAND_RESET  = 8'h00;
    localparam logic [7:0] SHUTDOWN_CODE_DEFAULT    = 8'hA5;

    localparam logic [3:0] BIT_LAST_DATA     = 4'h7;
    localparam logic [3:0] BIT_ACK           = 4'h8;
    localparam logic [3:0] BIT_FIRST         = 4'h0;

    typedef enum logic [2:0] {
        PH_ADDR,
        PH_REG,
        PH_WDATA,
        PH_RDATA,
        PH_IGNORE
    } phase_t;

endpackage : i2c_slave_pkg

// ==== logic/sync_two_flop.sv ====
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule : sync_two_flop

// ==== logic/i2c_register_slave_port.sv ====
`timescale 1ns/1ps
module i2c_register_slave_port #(
    parameter logic [7:0] SHUTDOWN_CODE = i2c_slave_pkg::SHUTDOWN_CODE_DEFAULT
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_we,
    input  wire logic [7:0] i_reg_rdata,
    output logic [7:0]      o_power_off_command,
    output logic            o_seal_mode
);

    logic       rst_core_n;
    logic       scl_s;
    logic       sda_s;
    logic       scl_s_n;
    logic       sda_s_n;
    logic       sda_prev_q;
    logic       bus_start;
    logic       bus_stop;
    logic       armed_q;
    logic       link_run_q;

    logic       ev_ptr_set_q;
    logic       ev_write_q;
    logic       ev_read_adv_q;
    logic [2:0] ev_s;
    logic [2:0] ev_prev_q;
    logic [2:0] ev_rise;

    logic [7:0] ptr_q;
    logic [7:0] ptr_next;
    logic       upd_q;
    logic [7:0] rd_hold_q;
    logic [7:0] power_off_command_q;
    logic       seal_q;
    logic       we_q;
    logic [7:0] wdata_q;

    i2c_slave_pkg::phase_t phase_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_q;
    logic [7:0] rx_byte;
    logic       ack_q;
    logic [7:0] tx_q;
    logic       sda_oe_q;

    // core reset: async assert, release through two flops
    sync_two_flop #(
        .WIDTH (1)
    ) u_rst_sync (
        .i_clk   (i_core_clk),
        .i_rst_n (i_rst_n),
        .i_d     (1'b1),
        .o_q     (rst_core_n)
    );

    sync_two_flop #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_core_n),
        .i_d     ({~i_scl, ~i_sda}),
        .o_q     ({scl_s_n, sda_s_n})
    );

    // inverted through the flops so reset shows a released bus, no false stop
    assign scl_s = ~scl_s_n;
    assign sda_s = ~sda_s_n;

    // start/stop detection in the core domain from synchronised pins
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            sda_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= sda_s;
        end
    end

    assign bus_start = scl_s & sda_prev_q & ~sda_s;
    assign bus_stop  = scl_s & ~sda_prev_q & sda_s;

    // the link logic is held in reset outside a frame; release waits for scl
    // low after start, so the next scl rise comes a full low phase later
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            armed_q    <= 1'b0;
            link_run_q <= 1'b0;
        end else if (bus_start || bus_stop) begin
            armed_q    <= bus_start;
            link_run_q <= 1'b0;
        end else if (armed_q && !scl_s) begin
            armed_q    <= 1'b0;
            link_run_q <= 1'b1;
        end
    end

    // link domain: clocked by scl, reset by the frame signal
    assign rx_byte = {shift_q[6:0], i_sda};

    always_ff @(posedge i_scl_clk or negedge link_run_q) begin
        if (!link_run_q) begin
            bit_cnt_q <= i2c_slave_pkg::BIT_FIRST;
            shift_q   <= 8'h00;
        end else begin
            if (bit_cnt_q == i2c_slave_pkg::BIT_ACK) begin
                bit_cnt_q <= i2c_slave_pkg::BIT_FIRST;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q   <= rx_byte;
            end
        end
    end

    always_ff @(posedge i_scl_clk or negedge link_run_q) begin
        if (!link_run_q) begin
            phase_q <= i2c_slave_pkg::PH_ADDR;
            ack_q   <= 1'b0;
            byte_q  <= 8'h00;
        end else if (bit_cnt_q == i2c_slave_pkg::BIT_LAST_DATA) begin
            case (phase_q)
                i2c_slave_pkg::PH_ADDR: begin
                    if (rx_byte[7:1] == i2c_slave_pkg::DEV_ADDR) begin
                        ack_q <= 1'b1;
                        if (rx_byte[i2c_slave_pkg::RW_BIT_POS]) begin
                            phase_q <= i2c_slave_pkg::PH_RDATA;
                        end else begin
                            phase_q <= i2c_slave_pkg::PH_REG;
                        end
                    end else begin
                        phase_q <= i2c_slave_pkg::PH_IGNORE;
                    end
                end
                i2c_slave_pkg::PH_REG: begin
                    if (rx_byte <= i2c_slave_pkg::REG_ADDR_MAX) begin
                        ack_q   <= 1'b1;
                        byte_q  <= rx_byte;
                        phase_q <= i2c_slave_pkg::PH_WDATA;
                    end else begin
                        phase_q <= i2c_slave_pkg::PH_IGNORE;
                    end
                end
                i2c_slave_pkg::PH_WDATA: begin
                    ack_q  <= 1'b1;
                    byte_q <= rx_byte;
                end
                default: begin
                    ack_q <= 1'b0;
                end
            endcase
        end else if (bit_cnt_q == i2c_slave_pkg::BIT_ACK) begin
            ack_q <= 1'b0;
            // master nack ends the read; otherwise keep supplying bytes
            if (phase_q == i2c_slave_pkg::PH_RDATA && i_sda) begin
                phase_q <= i2c_slave_pkg::PH_IGNORE;
            end
        end
    end

    // event levels last one scl period, long enough for the two-flop crossing;
    // a frame reset only drops them, which the core never sees as an event
    always_ff @(posedge i_scl_clk or negedge link_run_q) begin
        if (!link_run_q) begin
            ev_ptr_set_q  <= 1'b0;
            ev_write_q    <= 1'b0;
            ev_read_adv_q <= 1'b0;
        end else begin
            ev_ptr_set_q  <= (bit_cnt_q == i2c_slave_pkg::BIT_LAST_DATA)
                             && (phase_q == i2c_slave_pkg::PH_REG)
                             && (rx_byte <= i2c_slave_pkg::REG_ADDR_MAX);
            ev_write_q    <= (bit_cnt_q == i2c_slave_pkg::BIT_LAST_DATA)
                             && (phase_q == i2c_slave_pkg::PH_WDATA);
            ev_read_adv_q <= (bit_cnt_q == i2c_slave_pkg::BIT_FIRST)
                             && (phase_q == i2c_slave_pkg::PH_RDATA);
        end
    end

    // sda is only changed while scl is low
    // rd_hold_q is quasi-static: the core refreshes it right after the
    // first bit of a byte, eight scl periods before the next load
    always_ff @(negedge i_scl_clk or negedge link_run_q) begin
        if (!link_run_q) begin
            tx_q     <= 8'hFF;
            sda_oe_q <= 1'b0;
        end else if (bit_cnt_q == i2c_slave_pkg::BIT_ACK) begin
            sda_oe_q <= ack_q;
        end else if (phase_q == i2c_slave_pkg::PH_RDATA) begin
            if (bit_cnt_q == i2c_slave_pkg::BIT_FIRST) begin
                tx_q     <= {rd_hold_q[6:0], 1'b1};
                sda_oe_q <= ~rd_hold_q[7];
            end else begin
                tx_q     <= {tx_q[6:0], 1'b1};
                sda_oe_q <= ~tx_q[7];
            end
        end else begin
            sda_oe_q <= 1'b0;
        end
    end

    // open drain: only ever pulls low, scl is never driven
    assign o_sda    = 1'b0;
    assign o_sda_oe = sda_oe_q;

    // back in the core domain
    sync_two_flop #(
        .WIDTH (3)
    ) u_ev_sync (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_core_n),
        .i_d     ({ev_read_adv_q, ev_write_q, ev_ptr_set_q}),
        .o_q     (ev_s)
    );

    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ev_prev_q <= 3'h0;
        end else begin
            ev_prev_q <= ev_s;
        end
    end

    assign ev_rise = ev_s & ~ev_prev_q;

    assign ptr_next = (ptr_q == i2c_slave_pkg::REG_ADDR_HOLD)
                      ? ptr_q : ptr_q + 8'h01;

    // pointer survives a repeated start, so it lives in the core domain
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ptr_q <= 8'h00;
        end else if (ev_rise[0]) begin
            ptr_q <= byte_q;
        end else if (ev_rise[1] || ev_rise[2]) begin
            ptr_q <= ptr_next;
        end
    end

    // byte_q is stable for a whole scl period around its event
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            we_q    <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            we_q <= ev_rise[1] && (ptr_q <= i2c_slave_pkg::REG_ADDR_MAX);
            if (ev_rise[1]) begin
                wdata_q <= byte_q;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            power_off_command_q <= i2c_slave_pkg::POWER_OFF_COMMAND_RESET;
        end else if (ev_rise[1]
                     && ptr_q == i2c_slave_pkg::POWER_OFF_COMMAND_OFFSET) begin
            power_off_command_q <= byte_q;
        end
    end

    // seal mode is left only by reset; waking is outside this block
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            seal_q <= 1'b0;
        end else if (ev_rise[1] && byte_q == SHUTDOWN_CODE
                     && ptr_q == i2c_slave_pkg::POWER_OFF_COMMAND_OFFSET) begin
            seal_q <= 1'b1;
        end
    end

    // read data refreshed one cycle after any pointer change
    always_ff @(posedge i_core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            upd_q     <= 1'b0;
            rd_hold_q <= 8'h00;
        end else begin
            upd_q <= |ev_rise;
            if (upd_q) begin
                if (ptr_q == i2c_slave_pkg::POWER_OFF_COMMAND_OFFSET) begin
                    rd_hold_q <= power_off_command_q;
                end else begin
                    rd_hold_q <= i_reg_rdata;
                end
            end
        end
    end

    assign o_reg_addr          = ptr_q;
    assign o_reg_wdata         = wdata_q;
    assign o_reg_we            = we_q;
    assign o_power_off_command = power_off_command_q;
    assign o_seal_mode         = seal_q;

endmodule : i2c_register_slave_port

// ==== verification/i2c_register_slave_port_props.sv ====
`timescale 1ns/1ps
module i2c_register_slave_port_props #(
    parameter logic [7:0] SHUTDOWN_CODE = 8'hA5
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic       i_scl_clk,
    input wire logic       i_scl,
    input wire logic       o_sda_oe,
    input wire logic [7:0] o_reg_addr,
    input wire logic       o_reg_we,
    input wire logic [7:0] o_power_off_command,
    input wire logic       o_seal_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_seal_sticky: assert property (o_seal_mode |=> o_seal_mode)
        else $error("seal mode dropped");
    a_seal_cause: assert property ($rose(o_seal_mode) |-> o_power_off_command == SHUTDOWN_CODE)
        else $error("seal mode without shutdown code");
    a_cmd_by_write: assert property ($changed(o_power_off_command)
        |-> o_reg_we || $past(o_reg_we) || $past(o_reg_we, 2))
        else $error("command register changed without a write");
    a_we_single: assert property (o_reg_we |=> !o_reg_we)
        else $error("write strobe longer than one cycle");
    a_ptr_hold_zero: assert property (o_reg_we && $past(o_reg_addr) == 8'h00
        |-> o_reg_addr == 8'h00)
        else $error("pointer left register zero");
    a_ptr_advance: assert property (o_reg_we && $past(o_reg_addr) != 8'h00
        |-> o_reg_addr == $past(o_reg_addr) + 8'h01)
        else $error("pointer did not advance by one");
    a_we_in_range: assert property (o_reg_we |-> $past(o_reg_addr) <= 8'h1F)
        else $error("write to invalid register");
    a_oe_stable_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
        else $error("data drive changed while clock high");
    a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data drive started while clock high");
endmodule : i2c_register_slave_port_props

// ==== verification/i2c_host_model.sv ====
`timescale 1ns/1ps
module i2c_host_model (
    output logic      o_scl,
    output logic      o_sda_pull,
    input  wire logic i_sda
);
    localparam time HALF = 40ns;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // also serves as repeated start from a low clock
    task automatic bus_start();
        // small offset keeps link edges off the core clock edges
        #1 o_sda_pull = 1'b0;
        #HALF o_scl = 1'b1;
        #HALF o_sda_pull = 1'b1;
        #HALF o_scl = 1'b0;
        #HALF;
    endtask : bus_start
    task automatic bus_stop();
        o_sda_pull = 1'b1;
        #HALF o_scl = 1'b1;
        #HALF o_sda_pull = 1'b0;
        #HALF;
    endtask : bus_stop
    // data set while low, held through the whole high period
    task automatic clk_bit(input logic b, output logic s);
        o_sda_pull = !b;
        #HALF o_scl = 1'b1;
        #(HALF / 2) s = i_sda;
        #(HALF / 2) o_scl = 1'b0;
    endtask : clk_bit
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : put_byte
    task automatic get_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(!ack_it, s);
    endtask : get_byte
endmodule : i2c_host_model

// ==== verification/i2c_register_slave_port_tb.sv ====
`timescale 1ns/1ps
module i2c_register_slave_port_tb;
    localparam logic [7:0] CODE = 8'h3C;
    logic        core_clk, rst_n, scl, sda_pull, sda_bus, sda_o, sda_oe, reg_we, seal;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, pwr_cmd, prev_addr, b;
    logic [15:0] wq[$];
    int          mismatches, n_compared;
    assign sda_bus = ~(sda_pull | (sda_oe & ~sda_o));
    assign reg_rdata = reg_addr ^ 8'h5C;
    i2c_register_slave_port #(.SHUTDOWN_CODE(CODE)) u_i2c_register_slave_port (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_scl_clk(scl), .i_scl(scl),
        .i_sda(sda_bus), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_we(reg_we), .i_reg_rdata(reg_rdata),
        .o_power_off_command(pwr_cmd), .o_seal_mode(seal));
    i2c_host_model u_i2c_host_model (.o_scl(scl), .o_sda_pull(sda_pull), .i_sda(sda_bus));
    // pointer has already moved when the strobe shows, so log the older one
    always @(posedge core_clk) begin
        if (reg_we === 1'b1) wq.push_back({prev_addr, reg_wdata});
        prev_addr <= reg_addr;
    end
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic send(input logic [7:0] v, input logic exp_ack);
        logic a;
        u_i2c_host_model.put_byte(v, a);
        check("ack", {15'h0, exp_ack}, {15'h0, a});
    endtask : send
    task automatic wr1(input logic [7:0] r, input logic [7:0] d);
        u_i2c_host_model.bus_start();
        send(8'h54, 1'b1);
        send(r, 1'b1);
        send(d, 1'b1);
        u_i2c_host_model.bus_stop();
        repeat (4) @(posedge core_clk);
    endtask : wr1
    task automatic t_burst_write(input logic [7:0] r, input logic [7:0] r2);
        u_i2c_host_model.bus_start();
        send(8'h54, 1'b1);
        send(r, 1'b1);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        u_i2c_host_model.bus_stop();
        repeat (4) @(posedge core_clk);
        check("write0", {r, 8'h11}, wq.pop_front());
        check("write1", {r2, 8'h22}, wq.pop_front());
    endtask : t_burst_write
    task automatic t_refuse();
        u_i2c_host_model.bus_start();
        send(8'h56, 1'b0);
        send(8'h05, 1'b0);
        u_i2c_host_model.bus_stop();
        u_i2c_host_model.bus_start();
        send(8'h54, 1'b1);
        send(8'h20, 1'b0);
        u_i2c_host_model.bus_stop();
        check("no write", 16'h0, {12'h0, 4'(wq.size())});
    endtask : t_refuse
    task automatic t_abort();
        logic s;
        u_i2c_host_model.bus_start();
        send(8'h54, 1'b1);
        send(8'h09, 1'b1);
        repeat (4) u_i2c_host_model.clk_bit(1'b0, s);
        wr1(8'h0A, 8'h5A);
        check("after abort", {8'h0A, 8'h5A}, wq.pop_front());
    endtask : t_abort
    task automatic t_read(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
        u_i2c_host_model.bus_start();
        send(8'h54, 1'b1);
        send(r, 1'b1);
        u_i2c_host_model.bus_start();
        send(8'h55, 1'b1);
        u_i2c_host_model.get_byte(1'b1, b);
        check("read0", {8'h0, e0}, {8'h0, b});
        u_i2c_host_model.get_byte(1'b0, b);
        check("read1", {8'h0, e1}, {8'h0, b});
        #10 check("released", 16'h1, {15'h0, sda_bus});
        u_i2c_host_model.bus_stop();
    endtask : t_read
    task automatic t_power();
        wr1(8'h1F, 8'h12);
        check("cmd", 16'h0012, {8'h0, pwr_cmd});
        check("seal off", 16'h0, {15'h0, seal});
        void'(wq.pop_front());
        wr1(8'h1F, CODE);
        check("seal on", 16'h1, {15'h0, seal});
        void'(wq.pop_front());
        t_read(8'h1F, CODE, 8'h20 ^ 8'h5C);
    endtask : t_power
    task automatic finish_test();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #300us;
        mismatches++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        check("reset", 16'h0, {pwr_cmd, 6'h0, seal, sda_oe});
        t_burst_write(8'h05, 8'h06);
        t_burst_write(8'h00, 8'h00);
        t_refuse();
        t_abort();
        t_read(8'h07, 8'h07 ^ 8'h5C, 8'h08 ^ 8'h5C);
        t_read(8'h00, 8'h00 ^ 8'h5C, 8'h00 ^ 8'h5C);
        t_power();
        finish_test();
    end
endmodule : i2c_register_slave_port_tb
bind i2c_register_slave_port i2c_register_slave_port_props #(.SHUTDOWN_CODE(SHUTDOWN_CODE)) u_props (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl_clk(i_scl_clk), .i_scl(i_scl),
    .o_sda_oe(o_sda_oe), .o_reg_addr(o_reg_addr), .o_reg_we(o_reg_we),
    .o_power_off_command(o_power_off_command), .o_seal_mode(o_seal_mode));
